// ---- usb_ep_pkg.sv ----
// Shared constants for the endpoint B/C register block
package usb_ep_pkg;
   // Register byte addresses
   localparam logic [31:0] OFS_B_IE = 32'hfff0606c;
   localparam logic [31:0] OFS_B_IC = 32'hfff06070;
   localparam logic [31:0] OFS_B_IS = 32'hfff06074;
   localparam logic [31:0] OFS_B_ADDR = 32'hfff06078;
   localparam logic [31:0] OFS_B_LEN = 32'hfff0607c;
   localparam logic [31:0] OFS_C_INFO = 32'hfff06080;
   localparam logic [31:0] OFS_C_CTL = 32'hfff06084;

   // Reset value of every register
   localparam logic [31:0] RESET_WORD = 32'h00000000;

   // Endpoint B event flag positions
   localparam int EV_W = 6;
   localparam int B_CF_BIT = 5;
   localparam int B_BUSERR_BIT = 4;
   localparam int B_DMA_BIT = 3;
   localparam int B_ALT_BIT = 2;
   localparam int B_TOKEN_BIT = 1;
   localparam int B_STALL_BIT = 0;

   // Endpoint B transfer length width
   localparam int LEN_W = 20;

   // Endpoint C information fields
   localparam int C_TYPE_LSB = 29;
   localparam int C_DIR_BIT = 28;
   localparam int C_MPS_LSB = 16;
   localparam int MPS_W = 10;
   localparam int C_ALT_LSB = 12;
   localparam int C_INF_LSB = 8;
   localparam int C_CFG_LSB = 4;
   localparam int C_NUM_LSB = 0;
   localparam logic [31:0] INFO_WMASK = 32'h73ff0fff;

   // Endpoint C control bits
   localparam int C_ZLP_BIT = 6;
   localparam int C_UNSTALL_BIT = 5;
   localparam int C_THR_BIT = 4;
   localparam int C_STALL_BIT = 3;
   localparam int C_RDY_BIT = 2;
   localparam int C_RST_BIT = 1;
   localparam int C_EN_BIT = 0;

   // Isochronous FIFO free-space thresholds in bytes
   localparam logic [7:0] THR_SMALL = 8'h10;
   localparam logic [7:0] THR_LARGE = 8'h20;

   // Memory beat size
   localparam logic [31:0] BEAT_ADDR = 32'h00000004;
   localparam logic [19:0] BEAT_LEN = 20'h00004;

   // AXI responses
   localparam logic [1:0] RESP_OKAY = 2'b00;
   localparam logic [1:0] RESP_DECERR = 2'b11;

   typedef enum logic [1:0] {
      XFER_RSVD = 2'b00,
      XFER_BULK = 2'b01,
      XFER_INTR = 2'b10,
      XFER_ISO = 2'b11
   } xfer_type_e;
endpackage : usb_ep_pkg

// ---- usb_ep_dma.sv ----
// Address and byte counter for one endpoint's memory transfers
`timescale 1ns/1ps
module usb_ep_dma (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_start,
   input wire logic [31:0] i_addr,
   input wire logic [19:0] i_len,
   input wire logic i_ack,
   input wire logic i_err,
   output logic o_req,
   output logic [31:0] o_addr,
   output logic o_done,
   output logic o_err
);
   typedef enum logic {
      DMA_IDLE = 1'b0,
      DMA_RUN = 1'b1
   } dma_state_e;

   typedef struct packed {
      dma_state_e st;
      logic req;
      logic [31:0] addr;
      logic [19:0] left;
      logic done;
      logic err;
   } dma_s;

   dma_s s;
   dma_s n;

   // Walk the address one word per acknowledged beat
   always_comb begin
      n = s;
      n.done = 1'b0;
      n.err = 1'b0;
      unique case (s.st)
         DMA_IDLE: begin
            if (i_start) begin
               n.st = DMA_RUN;
               n.req = 1'b1;
               n.addr = i_addr;
               n.left = i_len;
            end
         end
         DMA_RUN: begin
            // A bus error ends the transfer; the rest is not retried
            if (i_err) begin
               n.st = DMA_IDLE;
               n.req = 1'b0;
               n.err = 1'b1;
            end else if (i_ack) begin
               n.addr = s.addr + usb_ep_pkg::BEAT_ADDR;
               // Partial last word still counts as one beat
               if (s.left <= usb_ep_pkg::BEAT_LEN) begin
                  n.st = DMA_IDLE;
                  n.req = 1'b0;
                  n.done = 1'b1;
               end else begin
                  n.left = s.left - usb_ep_pkg::BEAT_LEN;
               end
            end
         end
      endcase
   end

   // State register
   always_ff @(posedge i_clk) begin
      if (!i_rst_n) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   assign o_req = s.req;
   assign o_addr = s.addr;
   assign o_done = s.done;
   assign o_err = s.err;
endmodule : usb_ep_dma

// ---- usb_ep_regs.sv ----
// Endpoint B status/DMA and endpoint C info/control registers on AXI4-Lite
`timescale 1ns/1ps
// Functional notes
// - B status word, bit5 clear-feature, rest reserved
// - B bit4 set on system bus error
// - B bit3 set on DMA completion
// - B bit2 set on alternate setting change
// - B bit1 set on token received
// - B bit0 set on stall event
// - B 32-bit writable DMA address
// - B 20-bit writable length, upper reserved
// - C type field bits 30:29
// - C direction bit 28, 1 is IN
// - C max packet size bits 25:16
// - C alt read-only, interface/config/number writable
// - C control bit6 sends zero-length packet
// - C control bit5 write-one clears stall
// - C iso DMA threshold 16 or 32 bytes
// - C control bit3 sets stall
// - C DMA only while buffer-ready bit set
// - C bit1 resets endpoint, bit0 enables
// - B interrupt gated by enable word
// - B clear word write-one clears flag
module usb_ep_regs (
   input wire logic I_CLK_SYS,
   input wire logic I_RST_N,
   input wire logic [31:0] I_AWADDR,
   input wire logic I_AWVALID,
   output logic O_AWREADY,
   input wire logic [31:0] I_WDATA,
   input wire logic [3:0] I_WSTRB,
   input wire logic I_WVALID,
   output logic O_WREADY,
   output logic [1:0] O_BRESP,
   output logic O_BVALID,
   input wire logic I_BREADY,
   input wire logic [31:0] I_ARADDR,
   input wire logic I_ARVALID,
   output logic O_ARREADY,
   output logic [31:0] O_RDATA,
   output logic [1:0] O_RRESP,
   output logic O_RVALID,
   input wire logic I_RREADY,
   input wire logic I_EP_B_STALL_EV,
   input wire logic I_EP_B_TOKEN_EV,
   input wire logic I_EP_B_ALT_EV,
   input wire logic I_EP_B_CLR_FEAT_EV,
   output logic O_EP_B_MEM_REQ,
   output logic [31:0] O_EP_B_MEM_ADDR,
   input wire logic I_EP_B_MEM_ACK,
   input wire logic I_EP_B_MEM_ERR,
   output logic O_EP_B_IRQ,
   input wire logic [3:0] I_EP_C_ALT,
   input wire logic [7:0] I_EP_C_FIFO_FREE,
   input wire logic I_EP_C_ZLP_SENT,
   output logic O_EP_C_ENABLE,
   output logic O_EP_C_RESET,
   output logic O_EP_C_STALL,
   output logic O_EP_C_ZLP,
   output logic O_EP_C_DMA_GO,
   output logic [1:0] O_EP_C_TYPE,
   output logic O_EP_C_DIR,
   output logic [9:0] O_EP_C_MPS,
   output logic [3:0] O_EP_C_INTERFACE,
   output logic [3:0] O_EP_C_CONFIG,
   output logic [3:0] O_EP_C_EP_NUM
);
   typedef struct packed {
      logic aw_have;
      logic [31:0] aw_addr;
      logic w_have;
      logic [31:0] w_data;
      logic [3:0] w_strb;
      logic awready;
      logic wready;
      logic bvalid;
      logic [1:0] bresp;
      logic arready;
      logic rvalid;
      logic [1:0] rresp;
      logic [31:0] rdata;
      logic [5:0] b_flags;
      logic [5:0] b_ie;
      logic [31:0] b_addr;
      logic [19:0] b_len;
      logic b_start;
      logic b_irq;
      logic [31:0] c_info;
      logic c_zlp;
      logic c_thr;
      logic c_stall;
      logic c_rdy;
      logic c_en;
      logic c_rst;
      logic c_go;
   } regs_s;

   regs_s s;
   regs_s n;

   logic [31:0] wmask;
   logic [31:0] wmerge_b_addr;
   logic [31:0] wmerge_b_len;
   logic [31:0] wmerge_b_ie;
   logic [31:0] wmerge_c_info;
   logic wr_fire;
   logic [5:0] b_events;
   logic [5:0] b_clear;
   logic dma_done;
   logic dma_err;
   logic iso_sel;
   logic iso_ok;

   // Byte lanes from the write strobes
   genvar gi;
   generate
      for (gi = 0; gi < 4; gi++) begin : g_lane
         assign wmask[8*gi +: 8] = {8{s.w_strb[gi]}};
      end
   endgenerate

   // Strobe-merged candidate values for the enable, address, length and info words
   assign wmerge_b_addr = (s.b_addr & ~wmask) | (s.w_data & wmask);
   assign wmerge_b_len = ({12'h000, s.b_len} & ~wmask) | (s.w_data & wmask);
   assign wmerge_b_ie = ({26'h0000000, s.b_ie} & ~wmask) | (s.w_data & wmask);
   assign wmerge_c_info = (s.c_info & ~wmask) | (s.w_data & wmask);

   // Write commits once address and data are both held and no answer pends
   assign wr_fire = s.aw_have && s.w_have && !s.bvalid;

   // Event sources for endpoint B, in status bit order
   assign b_events = {I_EP_B_CLR_FEAT_EV, dma_err, dma_done,
                      I_EP_B_ALT_EV, I_EP_B_TOKEN_EV, I_EP_B_STALL_EV};

   // Write-one-to-clear mask, only when byte 0 is strobed
   assign b_clear = (wr_fire && s.aw_addr == usb_ep_pkg::OFS_B_IC && s.w_strb[0])
                    ? s.w_data[5:0] : 6'h00;

   // Iso threshold compare; other types ignore free space
   assign iso_sel = (s.c_info[30:29] == usb_ep_pkg::XFER_ISO);
   assign iso_ok = s.c_thr ? (I_EP_C_FIFO_FREE > usb_ep_pkg::THR_SMALL)
                           : (I_EP_C_FIFO_FREE > usb_ep_pkg::THR_LARGE);

   // Next-state logic for bus slave and all registers
   always_comb begin
      n = s;
      n.b_start = 1'b0;
      n.c_rst = 1'b0;

      // Address and data are caught independently, in either order
      if (I_AWVALID && s.awready) begin
         n.aw_have = 1'b1;
         n.aw_addr = I_AWADDR;
      end
      if (I_WVALID && s.wready) begin
         n.w_have = 1'b1;
         n.w_data = I_WDATA;
         n.w_strb = I_WSTRB;
      end
      if (s.bvalid && I_BREADY) begin
         n.bvalid = 1'b0;
      end

      // Hardware-side housekeeping first, so software writes win below
      if (I_EP_C_ZLP_SENT) begin
         n.c_zlp = 1'b0;
      end
      if (s.c_rst) begin
         n.c_stall = 1'b0;
         n.c_zlp = 1'b0;
      end

      // Register write decode
      if (wr_fire) begin
         n.aw_have = 1'b0;
         n.w_have = 1'b0;
         n.bvalid = 1'b1;
         n.bresp = usb_ep_pkg::RESP_OKAY;
         unique case (s.aw_addr)
            usb_ep_pkg::OFS_B_IE: begin
               n.b_ie = wmerge_b_ie[5:0];
            end
            usb_ep_pkg::OFS_B_IC, usb_ep_pkg::OFS_B_IS: begin
               // Clear word acts through b_clear; status is read-only
               n.bresp = usb_ep_pkg::RESP_OKAY;
            end
            usb_ep_pkg::OFS_B_ADDR: begin
               n.b_addr = wmerge_b_addr;
            end
            usb_ep_pkg::OFS_B_LEN: begin
               n.b_len = wmerge_b_len[19:0];
               // A non-zero length launches the transfer
               n.b_start = |wmerge_b_len[19:0];
            end
            usb_ep_pkg::OFS_C_INFO: begin
               // Reserved and alternate-setting bits never store
               n.c_info = wmerge_c_info & usb_ep_pkg::INFO_WMASK;
            end
            usb_ep_pkg::OFS_C_CTL: begin
               if (s.w_strb[0]) begin
                  n.c_zlp = s.w_data[usb_ep_pkg::C_ZLP_BIT];
                  n.c_thr = s.w_data[usb_ep_pkg::C_THR_BIT];
                  n.c_rdy = s.w_data[usb_ep_pkg::C_RDY_BIT];
                  n.c_en = s.w_data[usb_ep_pkg::C_EN_BIT];
                  n.c_rst = s.w_data[usb_ep_pkg::C_RST_BIT];
                  if (s.w_data[usb_ep_pkg::C_UNSTALL_BIT]) begin
                     n.c_stall = 1'b0;
                  end
                  // Set beats clear when both are written at once
                  if (s.w_data[usb_ep_pkg::C_STALL_BIT]) begin
                     n.c_stall = 1'b1;
                  end
               end
            end
            default: begin
               n.bresp = usb_ep_pkg::RESP_DECERR;
            end
         endcase
      end

      // Sticky status: a new event beats a clear in the same cycle
      n.b_flags = (s.b_flags & ~b_clear) | b_events;

      // Interrupt follows the flags one cycle later
      n.b_irq = |(s.b_flags & s.b_ie);

      // Endpoint C memory access permission
      n.c_go = s.c_en && s.c_rdy && !s.c_rst && (!iso_sel || iso_ok);

      // Read channel: one outstanding read, answered on the next edge
      if (I_ARVALID && s.arready) begin
         n.rvalid = 1'b1;
         n.rresp = usb_ep_pkg::RESP_OKAY;
         unique case (I_ARADDR)
            usb_ep_pkg::OFS_B_IE: n.rdata = {26'h0000000, s.b_ie};
            usb_ep_pkg::OFS_B_IC: n.rdata = usb_ep_pkg::RESET_WORD;
            usb_ep_pkg::OFS_B_IS: n.rdata = {26'h0000000, s.b_flags};
            usb_ep_pkg::OFS_B_ADDR: n.rdata = s.b_addr;
            usb_ep_pkg::OFS_B_LEN: n.rdata = {12'h000, s.b_len};
            usb_ep_pkg::OFS_C_INFO: begin
               n.rdata = {s.c_info[31:16], I_EP_C_ALT, s.c_info[11:0]};
            end
            usb_ep_pkg::OFS_C_CTL: begin
               // Unstall and reset are write-only and read as zero
               n.rdata = {25'h0000000, s.c_zlp, 1'b0, s.c_thr, s.c_stall,
                          s.c_rdy, 1'b0, s.c_en};
            end
            default: begin
               n.rdata = usb_ep_pkg::RESET_WORD;
               n.rresp = usb_ep_pkg::RESP_DECERR;
            end
         endcase
      end else if (s.rvalid && I_RREADY) begin
         n.rvalid = 1'b0;
      end

      // Ready outputs are registered; holding a half write blocks its channel
      n.awready = !n.aw_have && !n.bvalid;
      n.wready = !n.w_have && !n.bvalid;
      n.arready = !n.rvalid;
   end

   // Single state register, cleared by synchronous reset
   always_ff @(posedge I_CLK_SYS) begin
      if (!I_RST_N) begin
         s <= '0;
      end else begin
         s <= n;
      end
   end

   // Endpoint B memory transfer engine
   usb_ep_dma u_dma_b (
      .i_clk(I_CLK_SYS),
      .i_rst_n(I_RST_N),
      .i_start(s.b_start),
      .i_addr(s.b_addr),
      .i_len(s.b_len),
      .i_ack(I_EP_B_MEM_ACK),
      .i_err(I_EP_B_MEM_ERR),
      .o_req(O_EP_B_MEM_REQ),
      .o_addr(O_EP_B_MEM_ADDR),
      .o_done(dma_done),
      .o_err(dma_err)
   );

   // Bus outputs
   assign O_AWREADY = s.awready;
   assign O_WREADY = s.wready;
   assign O_BRESP = s.bresp;
   assign O_BVALID = s.bvalid;
   assign O_ARREADY = s.arready;
   assign O_RDATA = s.rdata;
   assign O_RRESP = s.rresp;
   assign O_RVALID = s.rvalid;

   // Endpoint outputs, all straight from the state register
   assign O_EP_B_IRQ = s.b_irq;
   assign O_EP_C_ENABLE = s.c_en;
   assign O_EP_C_RESET = s.c_rst;
   assign O_EP_C_STALL = s.c_stall;
   assign O_EP_C_ZLP = s.c_zlp;
   assign O_EP_C_DMA_GO = s.c_go;
   assign O_EP_C_TYPE = s.c_info[30:29];
   assign O_EP_C_DIR = s.c_info[usb_ep_pkg::C_DIR_BIT];
   assign O_EP_C_MPS = s.c_info[25:16];
   assign O_EP_C_INTERFACE = s.c_info[11:8];
   assign O_EP_C_CONFIG = s.c_info[7:4];
   assign O_EP_C_EP_NUM = s.c_info[3:0];

   // Checks on the block's own behaviour
   default clocking cb @(posedge I_CLK_SYS);
   endclocking
   default disable iff (!I_RST_N);

   sequence ic_write_s;
      wr_fire && s.aw_addr == usb_ep_pkg::OFS_B_IC && s.w_strb[0];
   endsequence

   sequence ctl_write_s;
      wr_fire && s.aw_addr == usb_ep_pkg::OFS_C_CTL && s.w_strb[0];
   endsequence

   b_clear_a: assert property (ic_write_s ##0 (s.w_data[3] && !dma_done)
                               |=> !s.b_flags[3])
      else $error("clear word did not clear dma flag");

   b_token_a: assert property (I_EP_B_TOKEN_EV |=> s.b_flags[1])
      else $error("token event not flagged");

   b_stall_ev_a: assert property (I_EP_B_STALL_EV |=> s.b_flags[0])
      else $error("stall event not flagged");

   b_alt_ev_a: assert property (I_EP_B_ALT_EV |=> s.b_flags[2])
      else $error("alternate setting not flagged");

   b_clr_feat_a: assert property (I_EP_B_CLR_FEAT_EV |=> s.b_flags[5])
      else $error("clear feature not flagged");

   b_dma_done_a: assert property (dma_done |=> s.b_flags[3])
      else $error("dma done not flagged");

   b_bus_err_a: assert property (I_EP_B_MEM_ERR && O_EP_B_MEM_REQ
                                 |=> ##1 s.b_flags[4])
      else $error("bus error not flagged");

   irq_gate_a: assert property (((s.b_flags & s.b_ie) == 6'h00)
                                |=> !O_EP_B_IRQ)
      else $error("interrupt without enabled flag");

   stall_set_a: assert property (ctl_write_s ##0 s.w_data[3]
                                 |=> O_EP_C_STALL)
      else $error("stall not set");

   unstall_a: assert property (ctl_write_s ##0 (s.w_data[5] && !s.w_data[3])
                               |=> !O_EP_C_STALL)
      else $error("stall not cleared");

   ready_gate_a: assert property (O_EP_C_DMA_GO
                                  |-> ($past(s.c_rdy) && $past(s.c_en)))
      else $error("dma go without ready and enable");

   iso_thr_a: assert property (O_EP_C_DMA_GO && $past(iso_sel)
                               |-> $past(iso_ok))
      else $error("iso dma below threshold");

   ep_reset_a: assert property (O_EP_C_RESET && !wr_fire
                                |=> (!O_EP_C_STALL && !O_EP_C_DMA_GO))
      else $error("endpoint reset not applied");

   resp_hold_a: assert property (O_BVALID && !I_BREADY |=> O_BVALID && $stable(O_BRESP))
      else $error("write response dropped early");
endmodule : usb_ep_regs

// ---- usb_ep_mem_model.sv ----
// Memory-side partner that answers endpoint B beat requests
`timescale 1ns/1ps
module usb_ep_mem_model (
   input wire logic i_clk,
   input wire logic i_rst_n,
   input wire logic i_req,
   input wire logic [31:0] i_addr,
   input wire logic i_fail,
   output logic o_ack,
   output logic o_err
);
   logic [31:0] seen[$];

   // One beat at a time; an idle cycle after each answer so no beat is answered twice
   initial begin
      o_ack = 1'b0;
      o_err = 1'b0;
      forever begin
         @(posedge i_clk);
         if (i_rst_n === 1'b1 && i_req === 1'b1) begin
            repeat ($urandom_range(2)) @(posedge i_clk); // Prompt or slow answer
            seen.push_back(i_addr);
            if (i_fail === 1'b1) o_err <= 1'b1;
            else o_ack <= 1'b1;
            @(posedge i_clk);
            o_ack <= 1'b0;
            o_err <= 1'b0;
         end
      end
   end
endmodule : usb_ep_mem_model

// ---- usb_device_endpoint_regs_tb.sv ----
// Self-checking bench for the endpoint B/C register block
`timescale 1ns/1ps
module usb_device_endpoint_regs_tb;
   logic clk, rst_n, awvalid, wvalid, bready, arvalid, rready, zlp_sent, fail;
   logic awready, wready, bvalid, arready, rvalid, b_req, b_ack, b_err, b_irq;
   logic c_en, c_rst, c_stall, c_zlp, c_go, c_dir;
   logic [31:0] awaddr, wdata, araddr, rdata, b_addr, v;
   logic [31:0] m_addr, m_len, m_info, m_ie, m_stat, m_ctl;
   logic [3:0] wstrb, ev, c_alt, c_inf, c_cfg, c_num;
   logic [7:0] fifo_free;
   logic [1:0] bresp, rresp, ctype;
   logic [9:0] c_mps;
   int err_total, samples_checked, rst_seen, n;
   int fpos[4] = '{0, 1, 2, 5};

   usb_ep_regs u_dut (
      .I_CLK_SYS(clk), .I_RST_N(rst_n), .I_AWADDR(awaddr), .I_AWVALID(awvalid),
      .O_AWREADY(awready), .I_WDATA(wdata), .I_WSTRB(wstrb), .I_WVALID(wvalid),
      .O_WREADY(wready), .O_BRESP(bresp), .O_BVALID(bvalid), .I_BREADY(bready),
      .I_ARADDR(araddr), .I_ARVALID(arvalid), .O_ARREADY(arready), .O_RDATA(rdata),
      .O_RRESP(rresp), .O_RVALID(rvalid), .I_RREADY(rready),
      .I_EP_B_STALL_EV(ev[0]), .I_EP_B_TOKEN_EV(ev[1]), .I_EP_B_ALT_EV(ev[2]),
      .I_EP_B_CLR_FEAT_EV(ev[3]), .O_EP_B_MEM_REQ(b_req), .O_EP_B_MEM_ADDR(b_addr),
      .I_EP_B_MEM_ACK(b_ack), .I_EP_B_MEM_ERR(b_err), .O_EP_B_IRQ(b_irq),
      .I_EP_C_ALT(c_alt), .I_EP_C_FIFO_FREE(fifo_free), .I_EP_C_ZLP_SENT(zlp_sent),
      .O_EP_C_ENABLE(c_en), .O_EP_C_RESET(c_rst), .O_EP_C_STALL(c_stall),
      .O_EP_C_ZLP(c_zlp), .O_EP_C_DMA_GO(c_go), .O_EP_C_TYPE(ctype), .O_EP_C_DIR(c_dir),
      .O_EP_C_MPS(c_mps), .O_EP_C_INTERFACE(c_inf), .O_EP_C_CONFIG(c_cfg),
      .O_EP_C_EP_NUM(c_num)
   );

   usb_ep_mem_model u_mem (
      .i_clk(clk), .i_rst_n(rst_n), .i_req(b_req), .i_addr(b_addr), .i_fail(fail),
      .o_ack(b_ack), .o_err(b_err)
   );

   // Clock at 5 ns period
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // Counts reset pulses so a stretched pulse shows up as an extra count
   always @(posedge clk) begin
      if (c_rst === 1'b1) rst_seen++;
   end

   task automatic check(input logic [31:0] seen, input logic [31:0] want);
      samples_checked++;
      if (seen !== want) begin
         err_total++;
         $display("BAD t=%0t seen=%h want=%h", $time, seen, want);
      end
   endtask : check

   task automatic close_out;
      $display("checks=%0d mismatches=%0d", samples_checked, err_total);
      if (err_total == 0 && samples_checked > 0) $display("[ PASS ]");
      else $display("[ FAIL ]");
      $finish;
   endtask : close_out

   // Write: both channels offered together, each released when taken
   task automatic wr(input logic [31:0] a, input logic [31:0] d, input logic [3:0] s,
                     input logic [1:0] want);
      bit aw, w;
      aw = 0;
      w = 0;
      @(posedge clk);
      awaddr <= a;
      wdata <= d;
      wstrb <= s;
      awvalid <= 1'b1;
      wvalid <= 1'b1;
      bready <= 1'b1;
      forever begin
         @(posedge clk);
         if (aw && w && bvalid === 1'b1) break;
         if (!aw && awready === 1'b1) begin
            aw = 1;
            awvalid <= 1'b0;
         end
         if (!w && wready === 1'b1) begin
            w = 1;
            wvalid <= 1'b0;
         end
      end
      bready <= 1'b0;
      check({30'h0, bresp}, {30'h0, want});
   endtask : wr

   task automatic rd(input logic [31:0] a, input logic [31:0] want, input logic [1:0] wr_);
      bit ar;
      ar = 0;
      @(posedge clk);
      araddr <= a;
      arvalid <= 1'b1;
      rready <= 1'b1;
      forever begin
         @(posedge clk);
         if (ar && rvalid === 1'b1) break;
         if (!ar && arready === 1'b1) begin
            ar = 1;
            arvalid <= 1'b0;
         end
      end
      rready <= 1'b0;
      check(rdata, want);
      check({30'h0, rresp}, {30'h0, wr_});
   endtask : rd

   // Reference read value of each mapped word
   function automatic logic [31:0] mdl(input logic [31:0] a);
      case (a)
         usb_ep_pkg::OFS_B_IE: return m_ie;
         usb_ep_pkg::OFS_B_IS: return m_stat;
         usb_ep_pkg::OFS_B_ADDR: return m_addr;
         usb_ep_pkg::OFS_B_LEN: return m_len;
         usb_ep_pkg::OFS_C_INFO: return m_info | {16'h0, c_alt, 12'h0};
         usb_ep_pkg::OFS_C_CTL: return m_ctl;
         default: return 32'h0;
      endcase
   endfunction : mdl

   task automatic rdm(input logic [31:0] a);
      rd(a, mdl(a), usb_ep_pkg::RESP_OKAY);
   endtask : rdm

   // Full-word write that also updates the reference
   task automatic wrm(input logic [31:0] a, input logic [31:0] d);
      wr(a, d, 4'hf, usb_ep_pkg::RESP_OKAY);
      case (a)
         usb_ep_pkg::OFS_B_IE: m_ie = d & 32'h0000003f;
         usb_ep_pkg::OFS_B_IC: m_stat = m_stat & ~d;
         usb_ep_pkg::OFS_B_ADDR: m_addr = d;
         usb_ep_pkg::OFS_B_LEN: m_len = d & 32'h000fffff;
         usb_ep_pkg::OFS_C_INFO: m_info = d & usb_ep_pkg::INFO_WMASK;
         usb_ep_pkg::OFS_C_CTL: begin
            m_ctl = (m_ctl & 32'h8) | (d & 32'h55);
            if (d[5]) m_ctl[3] = 1'b0;
            if (d[3]) m_ctl[3] = 1'b1;
            if (d[1]) m_ctl = m_ctl & 32'h37;
         end
         default: ;
      endcase
   endtask : wrm

   task automatic pulse(input int i);
      @(posedge clk);
      ev[i] <= 1'b1;
      @(posedge clk);
      ev[i] <= 1'b0;
   endtask : pulse

   // Hang guard reckoned well above the length of the sequence
   initial begin
      repeat (40000) @(posedge clk);
      err_total++;
      close_out();
   end

   initial begin
      {rst_n, awvalid, wvalid, bready, arvalid, rready, zlp_sent, fail} = '0;
      {awaddr, wdata, araddr, wstrb, ev, c_alt, fifo_free} = '0;
      {m_addr, m_len, m_info, m_ie, m_stat, m_ctl} = '0;
      v = $urandom(32'h5364);
      repeat (10) @(posedge clk);
      rst_n <= 1'b1;
      // Every word comes up zero; unmapped places are refused
      for (int k = 0; k < 7; k++) rdm(usb_ep_pkg::OFS_B_IE + 4 * k);
      rd(32'hfff06100, 32'h0, usb_ep_pkg::RESP_DECERR);
      wr(32'hfff06100, 32'hffffffff, 4'hf, usb_ep_pkg::RESP_DECERR);
      wr(usb_ep_pkg::OFS_B_IS, 32'hffffffff, 4'hf, usb_ep_pkg::RESP_OKAY);
      rdm(usb_ep_pkg::OFS_B_IS);
      // Each event sets its own flag; interrupt follows only the enabled flags
      for (int k = 0; k < 4; k++) begin
         pulse(k);
         m_stat[fpos[k]] = 1'b1;
         rdm(usb_ep_pkg::OFS_B_IS);
      end
      check({31'h0, b_irq}, 32'h0);
      wrm(usb_ep_pkg::OFS_B_IE, 32'h20);
      repeat (2) @(posedge clk);
      check({31'h0, b_irq}, 32'h1);
      wrm(usb_ep_pkg::OFS_B_IC, 32'h20);
      repeat (2) @(posedge clk);
      check({31'h0, b_irq}, 32'h0);
      rdm(usb_ep_pkg::OFS_B_IS);
      wrm(usb_ep_pkg::OFS_B_IC, 32'h3f);
      // Address with lane merge, then a three-beat transfer
      wrm(usb_ep_pkg::OFS_B_ADDR, $urandom & 32'hfffffffc);
      wr(usb_ep_pkg::OFS_B_ADDR, 32'h0, 4'h3, usb_ep_pkg::RESP_OKAY);
      m_addr = m_addr & 32'hffff0000;
      rdm(usb_ep_pkg::OFS_B_ADDR);
      wrm(usb_ep_pkg::OFS_B_LEN, 32'hfff0000c);
      n = 0;
      while (u_mem.seen.size() < 3 && n < 200) begin
         @(posedge clk);
         n++;
      end
      repeat (4) @(posedge clk);
      check(u_mem.seen.size(), 3);
      for (int k = 0; k < 3; k++) check(u_mem.seen[k], m_addr + 4 * k);
      m_stat[3] = 1'b1;
      rdm(usb_ep_pkg::OFS_B_IS);
      rdm(usb_ep_pkg::OFS_B_LEN);
      // A bus error ends the transfer and raises its own flag
      fail <= 1'b1;
      wrm(usb_ep_pkg::OFS_B_LEN, 32'h8);
      repeat (12) @(posedge clk);
      fail <= 1'b0;
      m_stat[4] = 1'b1;
      rdm(usb_ep_pkg::OFS_B_IS);
      check({31'h0, b_req}, 32'h0);
      // Every transfer type code with random fields
      for (int t = 0; t < 4; t++) begin
         c_alt <= 4'($urandom);
         v = $urandom;
         v[30:29] = 2'(t);
         wrm(usb_ep_pkg::OFS_C_INFO, v);
         rdm(usb_ep_pkg::OFS_C_INFO);
         check({30'h0, ctype}, t);
         check({c_mps, c_dir}, {v[25:16], v[28]});
         check({c_inf, c_cfg, c_num}, v[11:0]);
      end
      // Stall set wins over clear, clear alone removes it
      foreach (fpos[k]) begin
         v = (k == 0) ? 32'h8 : (k == 1) ? 32'h28 : (k == 2) ? 32'h20 : 32'h40;
         wrm(usb_ep_pkg::OFS_C_CTL, v);
         repeat (2) @(posedge clk);
         check({c_zlp, c_stall}, {m_ctl[6], m_ctl[3]});
         rdm(usb_ep_pkg::OFS_C_CTL);
      end
      @(posedge clk);
      zlp_sent <= 1'b1;
      @(posedge clk);
      zlp_sent <= 1'b0;
      m_ctl[6] = 1'b0;
      rdm(usb_ep_pkg::OFS_C_CTL);
      // Reset gives one pulse and drops the stall
      wrm(usb_ep_pkg::OFS_C_CTL, 32'h8);
      wrm(usb_ep_pkg::OFS_C_CTL, 32'h2);
      repeat (3) @(posedge clk);
      check({rst_seen[30:0], c_stall}, {31'h1, 1'b0});
      // Memory start gating over random control bits and free space, iso type, bulk type on the last pass
      wrm(usb_ep_pkg::OFS_C_INFO, 32'h60000000);
      for (int k = 0; k < 24; k++) begin
         v = $urandom & 32'h15;
         fifo_free <= (k < 4) ? 8'h10 + k[1:0] * 8'h10 : 8'($urandom);
         if (k == 23) wrm(usb_ep_pkg::OFS_C_INFO, 32'h20000000);
         // Threshold bit alternates so both limits meet free space at and above them
         wrm(usb_ep_pkg::OFS_C_CTL, (k < 4) ? {27'h0000000, ~k[0], 4'h5} : v);
         repeat (3) @(posedge clk);
         check({31'h0, c_go}, m_ctl[0] && m_ctl[2] && (m_info[30:29] != 2'b11 ||
               fifo_free > (m_ctl[4] ? 16 : 32)));
         check({31'h0, c_en}, m_ctl[0]);
      end
      close_out();
   end
endmodule : usb_device_endpoint_regs_tb
